// ===== core/ttc_core.sv
// Triggered timebase counter core
`timescale 1ns/1ns
`default_nettype none
`include "ttc_params.svh"

// Behaviour
// - Trigger high puts the control flip-flop in run.
// - Reset high with trigger low clears, releases outputs, stops counting.
// - Trigger wins over reset when both are high.
// - Trigger with timebase low loads zero immediately.
// - Trigger with timebase high loads zero on next falling edge.
// - Run counts on each timebase falling edge; stopped holds.
// - Grounded timing node makes timebase pin an input, else oscillator out.
// - Stopped state enables timing node pull-up unless external timebase.
// - Carry high during last ten counts of decimal variants.
// - Binary variant buffers the control flip-flop reset as an output.
// - Count spans 256, 100 or 60 periods by variant.
// - Divide-by-2 output, and divide-by-256 output rising 128 after trigger in the binary variant.
// - Without reset feedback the counter wraps freely.
// - All count stages update on the same timebase edge.
// - Counter and reset delay stay under half a timebase period.
module ttc_core #(
    parameter ttc_pkg::ttc_mode_t MODE     = ttc_pkg::TTC_MODE_BIN,
    parameter logic [15:0]        OSC_HALF = `TTC_OSC_HALF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              trigger_pin,
    input  wire logic              reset_pin,
    input  wire logic              timing_node_grounded,
    input  wire logic              timebase_pin_in,
    output logic                   timebase_pin_out,
    output logic                   timebase_pin_oe_n,
    output logic                   timing_node_pullup,
    output logic [7:0]             count_out,
    output logic [7:0]             count_oe_n,
    output logic                   carry_out,
    output logic                   buffered_reset,
    output logic                   div2_out,
    output logic                   div256_out,
    output ttc_pkg::ttc_stat_t     status
);
    import ttc_pkg::*;

    function automatic logic [7:0] max_count(input ttc_mode_t m);
        case (m)
            TTC_MODE_M100: max_count = `TTC_MAX_M100;
            TTC_MODE_M60:  max_count = `TTC_MAX_M60;
            default:       max_count = `TTC_MAX_BIN;
        endcase
    endfunction : max_count

    // Open-drain word, released while not counting
    function automatic logic [7:0] drain_word(input logic       act,
                                              input logic [7:0] bits);
        drain_word = act ? bits : 8'hFF;
    endfunction : drain_word

    localparam logic [7:0] CNT_MAX  = max_count(MODE);
    localparam logic [7:0] CARRY_LO = CNT_MAX - `TTC_CARRY_SPAN + 8'h01;

    // Pin synchronisers
    logic [1:0] trig_s_r;
    logic [1:0] rst_s_r;
    logic [1:0] gnd_s_r;
    logic [1:0] tb_s_r;
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            trig_s_r <= 2'h0;
            rst_s_r  <= 2'h0;
            gnd_s_r  <= 2'h0;
            tb_s_r   <= 2'h0;
        end
        else
        begin
            trig_s_r <= {trig_s_r[0], trigger_pin};
            rst_s_r  <= {rst_s_r[0], reset_pin};
            gnd_s_r  <= {gnd_s_r[0], timing_node_grounded};
            tb_s_r   <= {tb_s_r[0], timebase_pin_in};
        end

    wire trig = trig_s_r[1];
    wire rstp = rst_s_r[1];
    wire ext  = gnd_s_r[1];

    // Internal oscillator
    logic [15:0] osc_cnt_r;
    logic        osc_r;
    logic        run_r;
    wire         osc_wrap = (osc_cnt_r == OSC_HALF - 16'h0001);
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            osc_cnt_r <= 16'h0000;
            osc_r     <= 1'b1;
        end
        else if (ext || !run_r)
        begin
            osc_cnt_r <= 16'h0000;
            osc_r     <= 1'b1;
        end
        else
        begin
            osc_cnt_r <= osc_wrap ? 16'h0000 : osc_cnt_r + 16'h0001;
            osc_r     <= osc_wrap ? ~osc_r : osc_r;
        end

    // Timebase level and falling edge, one clock domain
    wire  tb_lvl = ext ? tb_s_r[1] : osc_r;
    logic tb_prev_r;
    always_ff @(posedge clk or posedge rst)
        if (rst)
            tb_prev_r <= 1'b1;
        else
            tb_prev_r <= tb_lvl;
    wire tb_fall = tb_prev_r && !tb_lvl;

    // Control flip-flop
    logic       loaded_r;
    logic [7:0] cnt_r;
    logic       d256_r;
    wire set_run  = trig;
    wire clr_run  = rstp && !trig;
    wire run_nxt  = set_run ? 1'b1 : (clr_run ? 1'b0 : run_r);
    wire trig_rise = set_run && !run_r;
    // Zero load at once if timebase low, else on next fall
    wire load_now  = trig_rise && !loaded_r && !tb_lvl;
    wire load_fall = run_r && !loaded_r && tb_fall;
    wire load_zero = load_now || load_fall;
    wire at_max    = (cnt_r == CNT_MAX);
    wire step      = run_r && loaded_r && tb_fall;
    wire [7:0] cnt_nxt = at_max ? 8'h00 : cnt_r + 8'h01;

    always_ff @(posedge clk or posedge rst)
        if (rst)
            run_r <= 1'b0;
        else
            run_r <= run_nxt;

    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            loaded_r <= 1'b0;
            cnt_r    <= 8'h00;
        end
        // Stop wins over a same-edge step, settled within one clock
        else if (clr_run)
        begin
            loaded_r <= 1'b0;
            cnt_r    <= 8'h00;
        end
        else if (load_zero)
        begin
            loaded_r <= 1'b1;
            cnt_r    <= 8'h00;
        end
        else if (step)
            cnt_r <= cnt_nxt;

    // Divide-by-256: high from count 128, rises 128 periods after start
    always_ff @(posedge clk or posedge rst)
        if (rst)
            d256_r <= 1'b0;
        else if (clr_run || load_zero)
            d256_r <= 1'b0;
        else if (step)
            d256_r <= cnt_nxt[7];

    // Count and drain outputs
    wire       active    = run_r && loaded_r;
    wire [7:0] drain_nxt = drain_word(active, cnt_r);
    wire       carry_nxt = active && (MODE != TTC_MODE_BIN)
                           && (cnt_r >= CARRY_LO);
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            count_out  <= 8'hFF;
            count_oe_n <= 8'hFF;
        end
        else
        begin
            count_out  <= drain_nxt;
            count_oe_n <= drain_nxt;
        end

    // Carry, divider taps and buffered reset
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            carry_out      <= 1'b0;
            buffered_reset <= 1'b0;
            div2_out       <= 1'b0;
            div256_out     <= 1'b0;
        end
        else
        begin
            carry_out      <= carry_nxt;
            buffered_reset <= clr_run;
            div2_out       <= active && cnt_r[0];
            div256_out     <= active && d256_r;
        end

    // Timebase pin and timing node
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            timing_node_pullup <= 1'b0;
            timebase_pin_out   <= 1'b1;
            timebase_pin_oe_n  <= 1'b1;
        end
        else
        begin
            timing_node_pullup <= !run_r && !ext;
            timebase_pin_out   <= osc_r;
            timebase_pin_oe_n  <= ext;
        end

    assign status = '{run:       run_r,
                      carry:     carry_out,
                      buf_reset: buffered_reset,
                      div2:      div2_out,
                      div256:    div256_out,
                      count:     cnt_r};
endmodule : ttc_core
`default_nettype wire

// ===== core/ttc_params.svh
// Constants for the triggered timebase counter
`ifndef TTC_PARAMS_SVH
`define TTC_PARAMS_SVH
`define TTC_CNT_W        8
`define TTC_MAX_BIN      8'hFF
`define TTC_MAX_M100     8'h63
`define TTC_MAX_M60      8'h3B
`define TTC_CARRY_SPAN   8'h0A
`define TTC_OSC_HALF     16'd8
`endif

// ===== core/ttc_pkg.sv
// Types for the triggered timebase counter
package ttc_pkg;
    typedef enum logic [1:0] {
        TTC_MODE_BIN  = 2'h0,
        TTC_MODE_M100 = 2'h1,
        TTC_MODE_M60  = 2'h2
    } ttc_mode_t;

    typedef struct packed {
        logic       run;
        logic       carry;
        logic       buf_reset;
        logic       div2;
        logic       div256;
        logic [7:0] count;
    } ttc_stat_t;
endpackage : ttc_pkg

// ===== verification/ttc_asserts.sv
// Port checks for the counter core
`timescale 1ns/1ns
`default_nettype none
module ttc_asserts (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               trigger_pin,
    input wire logic               reset_pin,
    input wire logic               timing_node_grounded,
    input wire logic               timebase_pin_oe_n,
    input wire logic               timing_node_pullup,
    input wire logic [7:0]         count_out,
    input wire logic [7:0]         count_oe_n,
    input wire logic               buffered_reset,
    input wire ttc_pkg::ttc_stat_t status
);
    import ttc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_drain_match: assert property (
        count_oe_n == count_out && ($past(status.run) || count_out == 8'hFF))
        else $error("drain mismatch");
    a_stop_free: assert property (
        !status.run [*2] |-> count_out == 8'hFF) else $error("not released");
    a_trig_run: assert property (
        trigger_pin [*5] |-> status.run) else $error("no run");
    a_reset_stop: assert property (
        (reset_pin && !trigger_pin) [*7] |-> !status.run && buffered_reset
        && count_out == 8'hFF) else $error("no stop");
    a_count_step: assert property (
        status.run [*2] |-> status.count inside {$past(status.count),
        $past(status.count) + 8'h01, 8'h00}) else $error("bad step");
    a_count_hold: assert property (
        !status.run [*2] |-> $stable(status.count)) else $error("moved");
    a_pullup_on: assert property (
        (!status.run && !timing_node_grounded) [*4] |-> timing_node_pullup)
        else $error("no pull-up");
    a_ext_input: assert property (
        timing_node_grounded [*4] |-> timebase_pin_oe_n && !timing_node_pullup)
        else $error("ext pin driven");
endmodule : ttc_asserts
bind ttc_core ttc_asserts u_chk (.clk(clk), .rst(rst), .reset_pin(reset_pin),
    .trigger_pin(trigger_pin), .timing_node_grounded(timing_node_grounded),
    .timebase_pin_oe_n(timebase_pin_oe_n), .count_out(count_out),
    .timing_node_pullup(timing_node_pullup), .count_oe_n(count_oe_n),
    .buffered_reset(buffered_reset), .status(status));
`default_nettype wire

// ===== verification/ttc_source.sv
// Timebase source and wired-OR feedback model
`timescale 1ns/1ns
`default_nettype none
module ttc_source (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tb_en,
    input  wire logic       park,
    input  wire logic       fb_en,
    input  wire logic [7:0] sel,
    input  wire logic [7:0] drain_n,
    input  wire logic       osc_oe_n,
    input  wire logic       osc,
    input  wire logic       casc,
    output logic            tb,
    output logic            fb,
    output logic [7:0]      casc_cnt
);
    logic       casc_q_r;
    wire        casc_fall = casc_q_r && !casc;
    // Next stage in a cascade, clocked by the carry's falling edge
    always_ff @(posedge clk)
    begin
        casc_q_r <= casc;
        casc_cnt <= rst ? 8'h00 : casc_cnt + {7'h00, casc_fall};
    end
    logic [1:0] div_r;
    logic       ph_r;
    always_ff @(posedge clk)
    begin
        div_r <= tb_en ? div_r + 2'h1 : 2'h0;
        ph_r  <= !tb_en ? park : ph_r ^ (div_r == 2'h3);
    end
    assign tb = osc_oe_n ? ph_r : osc;
    // High only while every selected drain is released
    assign fb = fb_en && &(drain_n | ~sel);
endmodule : ttc_source
`default_nettype wire

// ===== verification/tb_triggered_timebase_counter.sv
// Self-checking bench for the counter core
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_triggered_timebase_counter;
    import ttc_pkg::*;
    logic       clk, rst, trig, rin, gnd, ten, park, fen, tb, fb, tbo, tboe, pu;
    logic       brst, d256, cb, c60, d2;
    logic [7:0] sel, cnt, cnoe, cnt60, casc;
    ttc_stat_t  st;
    int         miscompares = 0;
    int         n_checks = 0;
    ttc_core #(.MODE(TTC_MODE_BIN), .OSC_HALF(16'h0004)) uut (.clk(clk),
        .rst(rst), .trigger_pin(trig), .reset_pin(rin | fb),
        .timing_node_grounded(gnd), .timebase_pin_in(tb), .timebase_pin_out(tbo),
        .timebase_pin_oe_n(tboe), .timing_node_pullup(pu), .count_out(cnt),
        .count_oe_n(cnoe), .carry_out(cb), .buffered_reset(brst),
        .div2_out(d2), .div256_out(d256), .status(st));
    // Decimal variant on the same pins, no feedback
    ttc_core #(.MODE(TTC_MODE_M60), .OSC_HALF(16'h0004)) uut_m60 (
        .clk(clk), .rst(rst), .trigger_pin(trig), .reset_pin(rin),
        .timing_node_grounded(gnd), .timebase_pin_in(tb),
        .timebase_pin_out(), .timebase_pin_oe_n(), .timing_node_pullup(),
        .count_out(cnt60), .count_oe_n(), .carry_out(c60),
        .buffered_reset(), .div2_out(), .div256_out(), .status());
    ttc_source src (.clk(clk), .rst(rst), .tb_en(ten), .park(park),
        .fb_en(fen), .sel(sel), .drain_n(cnoe), .osc_oe_n(tboe), .osc(tbo),
        .casc(c60), .tb(tb), .fb(fb), .casc_cnt(casc));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic pulses(input int n);
        ten <= 1'b1;
        tick(8 * n);
        ten <= 1'b0;
        tick(6);
        #1;
    endtask : pulses
    task automatic go;
        trig <= 1'b1;
        tick(6);
        #1;
        trig <= 1'b0;
    endtask : go
    task automatic halt;
        rin <= 1'b1;
        park <= 1'b0;
        tick(8);
        #1;
        `CHK("stop", 8'hFF, cnt)
        `CHK("bufrst", 1'b1, brst)
        rin <= 1'b0;
    endtask : halt
    task automatic s_low;
        go();
        `CHK("load", 8'h00, cnt)
        pulses(5);
        `CHK("step", 8'h05, cnt)
        `CHK("div2 odd", 1'b1, d2)
    endtask : s_low
    task automatic s_both;
        tick(1);
        rin <= 1'b1;
        go();
        `CHK("trig wins", 1'b1, st.run)
        halt();
    endtask : s_both
    task automatic s_high;
        park <= 1'b1;
        tick(4);
        go();
        `CHK("wait fall", 8'hFF, cnt)
        pulses(1);
        `CHK("first fall", 8'h00, cnt)
        halt();
    endtask : s_high
    task automatic s_mono;
        sel <= 8'h0A;
        fen <= 1'b1;
        go();
        pulses(9);
        `CHK("mid", 8'h09, cnt)
        pulses(3);
        `CHK("end", 8'hFF, cnt)
        fen <= 1'b0;
        halt();
    endtask : s_mono
    task automatic s_wrap;
        go();
        pulses(49);
        `CHK("carry 49", 1'b0, c60)
        pulses(1);
        `CHK("carry 50", 1'b1, c60)
        `CHK("m60 at 50", 8'h32, cnt60)
        `CHK("bin carry", 1'b0, cb)
        pulses(77);
        `CHK("d256 low", 1'b0, d256)
        `CHK("carry wrap", 1'b0, c60)
        pulses(1);
        `CHK("d256 high", 1'b1, d256)
        `CHK("div2 even", 1'b0, d2)
        pulses(130);
        `CHK("wrap", 8'h02, cnt)
        `CHK("m60 wrap", 8'h12, cnt60)
        `CHK("cascade", 8'h04, casc)
        halt();
    endtask : s_wrap
    task automatic s_osc;
        gnd <= 1'b0;
        tick(8);
        go();
        tick(40);
        #1;
        `CHK("osc drive", 1'b0, tboe)
        `CHK("osc count", 8'h04, cnt)
        halt();
        `CHK("pull-up", 1'b1, pu)
        gnd <= 1'b1;
        tick(6);
        #1;
        `CHK("ext no pull", 1'b0, pu)
    endtask : s_osc
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        miscompares++;
        stop_test();
    end
    initial
    begin
        rst = 1'b1;
        gnd = 1'b1;
        {trig, rin, ten, park, fen, sel} = 13'h0000;
        tick(3);
        rst <= 1'b0;
        tick(4);
        s_low();
        halt();
        s_both();
        s_high();
        s_mono();
        s_wrap();
        s_osc();
        stop_test();
    end
endmodule : tb_triggered_timebase_counter
`default_nettype wire
